// >>> aslpt_pkg.sv
package aslpt_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned FLICKER_HZ = 10;
  localparam int unsigned FLASH_HZ = 2;
  localparam int unsigned ALT_HZ = 5;
  localparam int unsigned BLINK_SEC = 3;
  // Half periods in cycles, for roughly fifty percent duty
  localparam int unsigned FLICKER_HALF = CLK_HZ / (2 * FLICKER_HZ);
  localparam int unsigned FLASH_HALF = CLK_HZ / (2 * FLASH_HZ);
  localparam int unsigned ALT_HALF = CLK_HZ / (2 * ALT_HZ);
  localparam int unsigned BLINK_CYC = CLK_HZ * BLINK_SEC;

  // ----------------------------------------------------------------
  // Register map (all offsets chosen locally)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_SETTLE = 8'h0c;
  localparam logic [7:0] ADDR_STATION = 8'h10;
  localparam logic [7:0] ADDR_LEDS = 8'h14;

  // Control bit positions
  localparam int unsigned CTRL_REQUIRED = 0;
  localparam int unsigned CTRL_DIAG = 1;
  localparam int unsigned CTRL_SYSFAULT = 2;
  localparam int unsigned CTRL_BLINK = 3;
  localparam int unsigned CTRL_RETEST = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  localparam logic [7:0] DRIVE_ADDRESS = 8'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PT_IDLE, PT_PROBE, PT_DONE} aslpt_pt_t;

  typedef struct packed {
    logic link;
    logic activity;
  } aslpt_port_t;

  typedef struct packed {
    logic link_green;
    logic act_yellow;
  } aslpt_port_led_t;

  typedef struct packed {
    logic red;
    logic green;
  } aslpt_bicolour_t;

endpackage

// >>> aslpt_top.sv
// Summary of operation
// - Port LEDs: no link both off; link without traffic green on, yellow off.
// - Link with traffic: green on, yellow flickers at 10 Hz.
// - Bus-fault LED off during cyclic data exchange while networked.
// - Bus-fault LED flashes 2 Hz when networked but not exchanging.
// - Bus-fault LED steady on with no network connection.
// - Status-fault LED off when no fault, no diagnostic and no blink window running.
// - Blink request flashes status-fault LED at 2 Hz for 3 s.
// - Status-fault LED steady on for watchdog, system fault or diagnostic.
// - Serial LED alternates red/green at 5 Hz while checking drive link.
// - Serial LED steady red when drive link failed and drive required.
// - Serial LED red and green steady when link works, drive required, but drive errors.
// - Serial LED green flashes 2 Hz: not required, no drive error.
// - Serial LED red+green flash 2 Hz: not required, drive error.
// - Serial LED steady green: link works, required, no drive error.
// - Presence test runs after power-up, serial LED flashing meanwhile.
// - Found drive gets last stored baud rate from nonvolatile memory.
// - Drive message settle delay set to match chosen baud rate.
// - Drive is given fixed station address 1.
// - After test: steady red if no drive, steady green if found, required and error-free.
module aslpt_top #(
  parameter int unsigned NPORTS = 2,
  parameter int unsigned PROBE_CYC = 125_000,
  parameter int unsigned BLINK_CYCLES = aslpt_pkg::BLINK_CYC,
  parameter int unsigned FLASH_HALF_CYC = aslpt_pkg::FLASH_HALF,
  parameter int unsigned FLICKER_HALF_CYC = aslpt_pkg::FLICKER_HALF,
  parameter int unsigned ALT_HALF_CYC = aslpt_pkg::ALT_HALF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Network state
  input wire aslpt_pkg::aslpt_port_t [NPORTS-1:0] network_port_pair,
  input wire logic net_connected,
  input wire logic cyclic_exchange,
  input wire logic watchdog_timeout,
  input wire logic blink_request,
  // Drive state
  input wire logic drive_responds,
  input wire logic drive_error,
  input wire logic [31:0] nv_baud_rate,
  // Drive configuration outputs
  output logic [31:0] drive_baud_rate,
  output logic [15:0] message_settle_delay,
  output logic [7:0] drive_station_addr,
  output logic drive_config_valid,
  // LEDs
  output aslpt_pkg::aslpt_port_led_t [NPORTS-1:0] port_led,
  output logic bus_fault_indicator,
  output logic status_fault_indicator,
  output aslpt_pkg::aslpt_bicolour_t serial_led
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Settle delay: about 3.5 characters of 11 bits, in microseconds
  function automatic logic [15:0] settle_for(input logic [31:0] baud);
    logic [31:0] b;
    // A zero rate would divide by zero, so it is taken as one
    b = (baud == 32'h0) ? 32'h1 : baud;
    settle_for = 16'((32'd38_500_000 / b) + 32'h1);
  endfunction

  // Half-period prescaler step
  function automatic logic [31:0] nxt(input logic [31:0] c, input int unsigned h);
    nxt = (c >= 32'(h - 1)) ? 32'h0 : c + 32'h1;
  endfunction

  // ----------------------------------------------------------------
  // Rate generators
  // ----------------------------------------------------------------
  // Prescaler counters and the toggles they drive
  logic [31:0] flash_cnt_q, flick_cnt_q, alt_cnt_q;
  logic flash_q, flick_q, alt_q;

  // Free-running toggles, each starting in the off phase
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flash_cnt_q <= 32'h0;
      flick_cnt_q <= 32'h0;
      alt_cnt_q <= 32'h0;
      flash_q <= 1'b0;
      flick_q <= 1'b0;
      alt_q <= 1'b0;
    end
    else
    begin
      flash_cnt_q <= nxt(flash_cnt_q, FLASH_HALF_CYC);
      flick_cnt_q <= nxt(flick_cnt_q, FLICKER_HALF_CYC);
      alt_cnt_q <= nxt(alt_cnt_q, ALT_HALF_CYC);
      if (flash_cnt_q >= 32'(FLASH_HALF_CYC - 1))
        flash_q <= ~flash_q;
      if (flick_cnt_q >= 32'(FLICKER_HALF_CYC - 1))
        flick_q <= ~flick_q;
      if (alt_cnt_q >= 32'(ALT_HALF_CYC - 1))
        alt_q <= ~alt_q;
    end
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic aw_have_q, w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic retest_pulse;

  // One write in flight; channels stall until its response is taken
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  wire wr_ctrl = do_write && (aw_addr_q == aslpt_pkg::ADDR_CTRL);
  assign retest_pulse = wr_ctrl && w_strb_q[0] && w_data_q[aslpt_pkg::CTRL_RETEST];

  // Write path; address and data may arrive in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= aslpt_pkg::RESP_OKAY;
      ctrl_q <= aslpt_pkg::CTRL_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_q == aslpt_pkg::ADDR_CTRL) ? aslpt_pkg::RESP_OKAY
                                                           : aslpt_pkg::RESP_SLVERR;
        if (wr_ctrl && w_strb_q[0])
          ctrl_q[3:0] <= w_data_q[3:0]; // Retest bit self-clears
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Presence test
  // ----------------------------------------------------------------
  aslpt_pkg::aslpt_pt_t pt_q;
  logic [31:0] pt_cnt_q;
  logic found_q;

  // Starts from reset or on software request, waits for the drive
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pt_q <= aslpt_pkg::PT_IDLE;
      pt_cnt_q <= 32'h0;
      found_q <= 1'b0;
      drive_baud_rate <= 32'h0;
      message_settle_delay <= 16'h0;
      drive_station_addr <= 8'h0;
      drive_config_valid <= 1'b0;
    end
    else
    begin
      unique case (pt_q)
        aslpt_pkg::PT_IDLE:
        begin
          pt_q <= aslpt_pkg::PT_PROBE;
          pt_cnt_q <= 32'h0;
          found_q <= 1'b0;
          drive_config_valid <= 1'b0;
        end
        aslpt_pkg::PT_PROBE:
        begin
          // A drive answer ends the probe early; silence ends it on timeout
          pt_cnt_q <= pt_cnt_q + 32'h1;
          if (drive_responds)
          begin
            found_q <= 1'b1;
            drive_baud_rate <= nv_baud_rate;
            message_settle_delay <= settle_for(nv_baud_rate);
            drive_station_addr <= aslpt_pkg::DRIVE_ADDRESS;
            drive_config_valid <= 1'b1;
            pt_q <= aslpt_pkg::PT_DONE;
          end
          else if (pt_cnt_q >= 32'(PROBE_CYC - 1))
            pt_q <= aslpt_pkg::PT_DONE;
        end
        aslpt_pkg::PT_DONE:
        begin
          if (retest_pulse)
            pt_q <= aslpt_pkg::PT_IDLE;
        end
        default: pt_q <= aslpt_pkg::PT_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Blink service timer
  // ----------------------------------------------------------------
  logic [31:0] blink_cnt_q;
  wire blinking = blink_cnt_q != 32'h0;
  // A start follows the written bit, not the stored one, so a write of 1
  // starts the window at once and a later write of 0 does not restart it
  wire blink_wr = wr_ctrl && w_strb_q[0] && w_data_q[aslpt_pkg::CTRL_BLINK];

  // Request restarts the 3 s window; a start beats the countdown
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      blink_cnt_q <= 32'h0;
    else if (blink_request || blink_wr)
      blink_cnt_q <= 32'(BLINK_CYCLES);
    else if (blinking)
      blink_cnt_q <= blink_cnt_q - 32'h1;
  end

  // ----------------------------------------------------------------
  // LED decode
  // ----------------------------------------------------------------
  // Required flag and the fault sources that light the status LED
  wire required = ctrl_q[aslpt_pkg::CTRL_REQUIRED];
  wire fault = watchdog_timeout || ctrl_q[aslpt_pkg::CTRL_SYSFAULT]
               || ctrl_q[aslpt_pkg::CTRL_DIAG];
  aslpt_pkg::aslpt_port_led_t [NPORTS-1:0] port_d;
  logic bf_d, sf_d;
  aslpt_pkg::aslpt_bicolour_t ser_d;

  // Port link and activity
  always_comb
  begin
    for (int i = 0; i < NPORTS; i++)
    begin
      port_d[i].link_green = network_port_pair[i].link;
      port_d[i].act_yellow = network_port_pair[i].link
                             && network_port_pair[i].activity && flick_q;
    end
  end

  // Bus fault and status fault
  assign bf_d = !net_connected ? 1'b1
              : cyclic_exchange ? 1'b0
              : flash_q;
  assign sf_d = fault ? 1'b1
              : blinking ? flash_q
              : 1'b0;

  // Serial-link bicolour LED
  always_comb
  begin
    ser_d = '{red: 1'b0, green: 1'b0};
    if (pt_q != aslpt_pkg::PT_DONE)
      ser_d = '{red: alt_q, green: !alt_q};
    else if (!found_q)
      ser_d = '{red: 1'b1, green: 1'b0};
    else if (!drive_responds)
    begin
      // A drive lost after the test only shows if it is required
      if (required)
        ser_d = '{red: 1'b1, green: 1'b0};
      else
        ser_d = '{red: 1'b0, green: 1'b0};
    end
    else if (!required)
      ser_d = '{red: drive_error && flash_q, green: flash_q};
    else if (drive_error)
      ser_d = '{red: 1'b1, green: 1'b1};
    else
      ser_d = '{red: 1'b0, green: 1'b1};
  end

  // LED output registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_led <= '0;
      bus_fault_indicator <= 1'b0;
      status_fault_indicator <= 1'b0;
      serial_led <= '0;
    end
    else
    begin
      port_led <= port_d;
      bus_fault_indicator <= bf_d;
      status_fault_indicator <= sf_d;
      serial_led <= ser_d;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic rd_ok;
  // Register select; unmapped offsets answer with an error and zero
  always_comb
  begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      aslpt_pkg::ADDR_CTRL: rd_mux = {28'h0, ctrl_q[3:0]};
      aslpt_pkg::ADDR_STATUS: rd_mux = {26'h0, drive_error, drive_responds,
                                        found_q, drive_config_valid, pt_q};
      aslpt_pkg::ADDR_BAUD: rd_mux = drive_baud_rate;
      aslpt_pkg::ADDR_SETTLE: rd_mux = {16'h0, message_settle_delay};
      aslpt_pkg::ADDR_STATION: rd_mux = {24'h0, drive_station_addr};
      aslpt_pkg::ADDR_LEDS: rd_mux = {26'h0, serial_led, bus_fault_indicator,
                                      status_fault_indicator, blinking, required};
      default:
      begin
        rd_mux = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= aslpt_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? aslpt_pkg::RESP_OKAY : aslpt_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// >>> aslpt_drive_model.sv
module aslpt_drive_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Scenario controls
  input wire logic drv_present,
  input wire logic drv_err,
  input wire logic [3:0] drv_dly,
  // Serial link state seen by the adapter
  output logic drive_responds,
  output logic drive_error
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] boot_q;
  // Base unit boots for drv_dly cycles before it answers
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !drv_present)
      boot_q <= 4'h0;
    else if (boot_q != drv_dly)
      boot_q <= boot_q + 4'h1;
  end
  // A silent drive reports nothing, so its error flag drops too
  assign drive_responds = drv_present && (boot_q == drv_dly);
  assign drive_error = drive_responds && drv_err;
endmodule

// >>> aslpt_sva.sv
module aslpt_sva #(
  parameter int unsigned NPORTS = 2,
  parameter int unsigned FLASH_HALF_CYC = aslpt_pkg::FLASH_HALF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Watched inputs
  input wire aslpt_pkg::aslpt_port_t [NPORTS-1:0] network_port_pair,
  input wire logic net_connected,
  input wire logic cyclic_exchange,
  input wire logic watchdog_timeout,
  input wire logic [31:0] nv_baud_rate,
  // Watched outputs
  input wire logic [31:0] drive_baud_rate,
  input wire logic [7:0] drive_station_addr,
  input wire logic drive_config_valid,
  input wire aslpt_pkg::aslpt_port_led_t [NPORTS-1:0] port_led,
  input wire logic bus_fault_indicator,
  input wire logic status_fault_indicator
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  // Attempts start one edge after reset is seen high, so the edge that
  // releases reset does not judge the reset values of the LEDs
  logic live_q;
  default disable iff (!aresetn || !live_q);
  logic [31:0] hold_q;
  logic [31:0] flat_q;
  // Idle-network time and time since the fault LED last moved
  always_ff @(posedge aclk)
  begin
    live_q <= aresetn;
    hold_q <= (aresetn && net_connected && !cyclic_exchange) ? hold_q + 32'h1 : 32'h0;
    flat_q <= (!aresetn || $changed(bus_fault_indicator)) ? 32'h0 : flat_q + 32'h1;
  end
  sequence s_found;
    $rose(drive_config_valid);
  endsequence
  property p_port_off;
    !network_port_pair[0].link |=> port_led[0] == 2'h0;
  endproperty
  property p_port_quiet;
    network_port_pair[0].link && !network_port_pair[0].activity |=> port_led[0] == 2'h2;
  endproperty
  property p_port_busy;
    network_port_pair[0].link && network_port_pair[0].activity |=> port_led[0].link_green;
  endproperty
  property p_bf_exch;
    net_connected && cyclic_exchange |=> !bus_fault_indicator;
  endproperty
  property p_bf_flash;
    hold_q > FLASH_HALF_CYC + 32'h3 |-> flat_q <= FLASH_HALF_CYC + 32'h1;
  endproperty
  property p_bf_off_net;
    !net_connected |=> bus_fault_indicator;
  endproperty
  property p_sf_wdog;
    watchdog_timeout |=> status_fault_indicator;
  endproperty
  property p_baud;
    s_found |-> drive_baud_rate == nv_baud_rate;
  endproperty
  property p_addr;
    drive_config_valid |-> drive_station_addr == 8'h01;
  endproperty
  a_port_off: assert property (p_port_off) else $error("port LEDs lit without link");
  a_port_quiet: assert property (p_port_quiet) else $error("idle port LEDs wrong");
  a_port_busy: assert property (p_port_busy) else $error("busy port green off");
  a_bf_exch: assert property (p_bf_exch) else $error("bus fault lit in exchange");
  a_bf_flash: assert property (p_bf_flash) else $error("bus fault not flashing");
  a_bf_off_net: assert property (p_bf_off_net) else $error("bus fault dark offline");
  a_sf_wdog: assert property (p_sf_wdog) else $error("status fault dark on timeout");
  a_baud: assert property (p_baud) else $error("baud rate not restored");
  a_addr: assert property (p_addr) else $error("station address wrong");
endmodule
bind aslpt_top aslpt_sva #(.NPORTS(NPORTS), .FLASH_HALF_CYC(FLASH_HALF_CYC)) u_sva (.*);

// >>> adapter_status_led_presence_test_tb.sv
module adapter_status_led_presence_test_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, drive_station_addr;
  logic [31:0] s_axi_wdata, s_axi_rdata, nv_baud_rate, drive_baud_rate, rd;
  logic [3:0] s_axi_wstrb, drv_dly;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  aslpt_pkg::aslpt_port_t [1:0] network_port_pair;
  logic net_connected, cyclic_exchange, watchdog_timeout, blink_request, eq;
  logic drive_responds, drive_error, drive_config_valid, drv_present, drv_err;
  logic [15:0] message_settle_delay;
  aslpt_pkg::aslpt_port_led_t [1:0] port_led;
  logic bus_fault_indicator, status_fault_indicator;
  aslpt_pkg::aslpt_bicolour_t serial_led;
  logic [4:0] hi, lo, v;
  int fail_count, n_tests;
  integer seed;
  aslpt_top #(.PROBE_CYC(8), .BLINK_CYCLES(60), .FLASH_HALF_CYC(4), .FLICKER_HALF_CYC(2),
    .ALT_HALF_CYC(3)) dut (.*);
  aslpt_drive_model u_drv (.*);
  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] settle_exp(input logic [31:0] b);
    return 32'h024b_76a0 / b + 32'h1;
  endfunction
  // Record which LED levels show up over n cycles
  task automatic watch(input int n);
    hi = 5'h0;
    lo = 5'h0;
    eq = 1'h1;
    repeat (3) @(posedge aclk);
    repeat (n)
    begin
      @(negedge aclk);
      v = {serial_led.red, serial_led.green, status_fault_indicator, bus_fault_indicator,
        port_led[0].act_yellow};
      hi |= v;
      lo |= ~v;
      if (serial_led.red !== serial_led.green) eq = 1'h0;
    end
    @(posedge aclk);
  endtask
  task automatic results;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Register bus master
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    rs = 2'hx;
    hb = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int t = 0; t < 40 && !hb; t++)
    begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      if (hb) rs = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'h0;
      if (hw) s_axi_wvalid <= 1'h0;
      if (hb) s_axi_bready <= 1'h0;
    end
    chk("bresp", 32'(rs), 32'(er));
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ha, hr;
    rd = 32'hx;
    rs = 2'hx;
    hr = 1'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int t = 0; t < 40 && !hr; t++)
    begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      if (hr) {rd, rs} = {s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'h0;
      if (hr) s_axi_rready <= 1'h0;
    end
  endtask
  // ----------------------------------------------------------------
  // Clock, reset and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end
  initial
  begin
    #40000;
    fail_count++;
    results();
  end
  // Main sequence
  initial
  begin
    seed = 32'h92dc;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'hf;
    {net_connected, cyclic_exchange, watchdog_timeout, blink_request, drv_err} = 5'h10;
    network_port_pair = 4'h3;
    drv_present = 1'h1;
    drv_dly = 4'h6;
    nv_baud_rate = 32'h2580 + 32'($random(seed) & 32'hffff);
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk("alternate", 32'(serial_led.red ^ serial_led.green), 32'h1);
    for (int t = 0; t < 60 && drive_config_valid !== 1'h1; t++) @(posedge aclk);
    chk("addr", 32'(drive_station_addr), 32'h1);
    chk("baud", drive_baud_rate, nv_baud_rate);
    chk("settle", 32'(message_settle_delay), settle_exp(nv_baud_rate) & 32'hffff);
    watch(12);
    chk("serial", 32'({hi[4:3], lo[4:3]}), 32'h7);
    chk("bf flash", 32'({hi[1], lo[1]}), 32'h3);
    chk("flicker", 32'({hi[0], lo[0]}), 32'h3);
    drv_err <= 1'h1;
    watch(12);
    chk("serial", 32'({eq, hi[4:3], lo[4:3]}), 32'h1f);
    axi_wr(aslpt_pkg::ADDR_CTRL, 32'h1, aslpt_pkg::RESP_OKAY);
    watch(10);
    chk("serial", 32'({hi[4:3], lo[4:3]}), 32'hc);
    drv_err <= 1'h0;
    watch(10);
    chk("serial", 32'({hi[4:3], lo[4:3]}), 32'h6);
    drv_present <= 1'h0;
    watch(10);
    chk("serial", 32'({hi[4:3], lo[4:3]}), 32'h9);
    axi_wr(aslpt_pkg::ADDR_CTRL, 32'h11, aslpt_pkg::RESP_OKAY);
    repeat (20) @(posedge aclk);
    watch(10);
    chk("serial", 32'({hi[4:3], lo[4:3]}), 32'h9);
    axi_rd(aslpt_pkg::ADDR_STATUS);
    chk("status", 32'({rd[3], rd[1:0]}), 32'h2);
    axi_rd(aslpt_pkg::ADDR_STATION);
    chk("station rd", rd, 32'(aslpt_pkg::DRIVE_ADDRESS));
    axi_rd(aslpt_pkg::ADDR_SETTLE);
    chk("settle rd", rd, settle_exp(nv_baud_rate) & 32'hffff);
    axi_wr(aslpt_pkg::ADDR_CTRL, 32'h2, aslpt_pkg::RESP_OKAY);
    watch(8);
    chk("sf diag", 32'({hi[2], lo[2]}), 32'h2);
    axi_wr(aslpt_pkg::ADDR_CTRL, 32'h0, aslpt_pkg::RESP_OKAY);
    watch(8);
    chk("sf clear", 32'({hi[2], lo[2]}), 32'h1);
    axi_wr(aslpt_pkg::ADDR_CTRL, 32'h4, aslpt_pkg::RESP_OKAY);
    watch(8);
    chk("sf sys", 32'({hi[2], lo[2]}), 32'h2);
    axi_wr(aslpt_pkg::ADDR_CTRL, 32'h0, aslpt_pkg::RESP_OKAY);
    axi_wr(aslpt_pkg::ADDR_CTRL, 32'h8, aslpt_pkg::RESP_OKAY);
    watch(12);
    chk("sf blink", 32'({hi[2], lo[2]}), 32'h3);
    axi_wr(aslpt_pkg::ADDR_CTRL, 32'h0, aslpt_pkg::RESP_OKAY);
    repeat (60) @(posedge aclk);
    watch(10);
    chk("sf after", 32'({hi[2], lo[2]}), 32'h1);
    blink_request <= 1'h1;
    @(posedge aclk);
    blink_request <= 1'h0;
    watch(12);
    chk("sf pulse", 32'({hi[2], lo[2]}), 32'h3);
    repeat (70) @(posedge aclk);
    axi_wr(8'h18, 32'h1, aslpt_pkg::RESP_SLVERR);
    axi_rd(aslpt_pkg::ADDR_CTRL);
    chk("ctrl kept", rd, 32'h0);
    axi_rd(8'h1c);
    chk("unmapped", rd, 32'h0);
    chk("unmapped resp", 32'(rs), 32'(aslpt_pkg::RESP_SLVERR));
    // Random network states, judged once the registered LEDs settle
    repeat (40)
    begin
      {network_port_pair, net_connected, cyclic_exchange, watchdog_timeout} <= 7'($random(seed));
      repeat (3) @(posedge aclk);
      for (int i = 0; i < 2; i++)
      begin
        chk("green", 32'(port_led[i].link_green), 32'(network_port_pair[i].link));
        if (!(network_port_pair[i].link && network_port_pair[i].activity))
          chk("yellow", 32'(port_led[i].act_yellow), 32'h0);
      end
      if (!net_connected)
        chk("bf", 32'(bus_fault_indicator), 32'h1);
      else if (cyclic_exchange)
        chk("bf", 32'(bus_fault_indicator), 32'h0);
      chk("sf", 32'(status_fault_indicator), 32'(watchdog_timeout));
    end
    results();
  end
endmodule
